// >>> logic/card_sel_pkg.sv
// Constants and types for the card file selection and status logic.
package card_sel_pkg;
    localparam logic [7:0] ADDR_CMD      = 8'h00;
    localparam logic [7:0] ADDR_COND     = 8'h04;
    localparam logic [7:0] ADDR_SEARCH   = 8'h08;
    localparam logic [7:0] ADDR_GO       = 8'h0c;
    localparam logic [7:0] ADDR_RECPTR   = 8'h10;
    localparam logic [7:0] ADDR_STATUS   = 8'h14;
    localparam logic [7:0] ADDR_SELSTATE = 8'h18;
    localparam logic [7:0] ADDR_TAGIDX   = 8'h1c;
    localparam logic [7:0] ADDR_TAG      = 8'h20;

    localparam logic [7:0] INS_SELECT    = 8'ha4;
    localparam logic [7:0] INS_INCREMENT = 8'h32;
    localparam logic [7:0] INS_CHANNEL   = 8'h70;
    localparam logic [7:0] CHAN_OPEN     = 8'h00;
    localparam logic [7:0] CHAN_CLOSE    = 8'h80;

    localparam logic [7:0] P1_BY_FID     = 8'h00;
    localparam logic [7:0] P1_CHILD      = 8'h01;
    localparam logic [7:0] P1_PARENT     = 8'h03;
    localparam logic [7:0] P1_BY_AID     = 8'h04;
    localparam logic [7:0] P1_PATH_ROOT  = 8'h08;
    localparam logic [7:0] P1_PATH_CUR   = 8'h09;
    localparam logic [7:0] P2_NO_DATA    = 8'h0c;
    localparam logic [2:0] P2_RET_TEMPL  = 3'h1;

    localparam logic [15:0] SW_OK        = 16'h9000;
    localparam logic [7:0]  SW1_PENDING  = 8'h91;
    localparam logic [15:0] SW_TK_BUSY   = 16'h9300;
    localparam logic [15:0] SW_INC_MAX   = 16'h9850;
    localparam logic [15:0] SW_AUTH_ERR  = 16'h9862;
    localparam logic [15:0] SW_NO_CHAN   = 16'h6881;
    localparam logic [15:0] SW_NO_FUNC   = 16'h6a81;
    localparam logic [15:0] SW_NOT_FOUND = 16'h6a82;
    localparam logic [15:0] SW_BAD_P1P2  = 16'h6a86;
    localparam logic [15:0] SW_BAD_INS   = 16'h6d00;

    localparam logic [7:0] TAG_TEMPLATE  = 8'h62;
    localparam logic [7:0] OBJ_TAGS [8]  = '{8'h82, 8'h83, 8'h84, 8'ha5,
                                            8'h8a, 8'h00, 8'hc6, 8'h81};
    localparam logic [7:0] SEC_TAGS [4]  = '{8'h86, 8'h8b, 8'h8c, 8'hab};
    localparam int         OBJ_FID       = 1;
    localparam int         OBJ_NAME      = 2;
    localparam int         OBJ_PROP      = 3;
    localparam int         OBJ_SEC       = 5;
    localparam int         OBJ_TOTAL     = 7;

    typedef enum logic [1:0] {
        KIND_ROOT, KIND_DIR, KIND_APP, KIND_ELEM
    } kind_type;

    typedef enum logic [1:0] {
        SRC_CHILD, SRC_PARENT, SRC_PARENT_CHILD, SRC_ROOT
    } src_type;
endpackage : card_sel_pkg

// >>> logic/card_sel_core.sv
// File selection, channel handling and status word logic behind APB.
//
// Contract
// - Increment at maximum value answers status 98 50.
// - Application authentication failure answers status 98 62.
// - Status 91 xx and 93 00 only when terminal declared toolkit.
// - Logical channel number is taken from CLA bits one and zero.
// - Channels 0 to 3 exist; channel 0 is always open.
// - Channel management opens and closes; the card picks the number.
// - Unsupported command answers an error status and does nothing.
// - Successful selection leaves the record pointer undefined.
// - P1 selects by identifier, child, parent, name, or path.
// - P2 bits 7 and 6 control session only for name selection.
// - P2 bit 8 low, bits 5 to 3 ask template or no data.
// - P2 bits 2 and 1 pick first, last, next or previous match.
// - P1 00 with empty data and P2 0C selects the root.
// - Identifier search: children, then parent, then parent's children.
// - P2 bits 2 and 1 are ignored unless P1 is 04.
// - A right truncated application identifier may still match.
// - Response starts with template tag 62, then length and contents.
// - Template objects appear in fixed order, new ones only at end.
// - Directory order 82 83 84 A5 8A security C6 then 81.
// - Name only for applications; identifier and proprietary rules.
// - Exactly one security object, tag 86, 8B, 8C or AB.
// - Normal completion answers status 90 00.
`timescale 1ns/10ps
module card_sel_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    typedef struct packed {
        logic [31:0]                cmd;
        logic [15:0]                cond;
        logic [10:0]                search;
        logic [15:0]                sw;
        logic                       done;
        logic [3:1]                 chan_open;
        logic [1:0]                 last_chan;
        card_sel_pkg::kind_type     kind;
        card_sel_pkg::src_type      src;
        logic [1:0]                 session;
        logic [1:0]                 occurrence;
        logic                       rec_valid;
        logic                       templ_req;
        logic [7:0]                 mask;
        logic [1:0]                 sec;
        logic [3:0]                 tag_idx;
        logic [31:0]                rdata;
        logic                       rerr;
    } state_type;

    state_type st_ff;
    state_type nxt_st;

    // Fields of the staged command and the condition flags.
    logic [7:0] cla;
    logic [7:0] ins;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [1:0] chan;
    logic       data_present;
    logic       le_present;
    logic       tk_declared;
    logic       inc_at_max;
    logic       auth_fail;
    logic       tk_pending;
    logic       tk_busy;
    logic [7:0] tk_len;
    logic       hit_child;
    logic       hit_parent;
    logic       hit_parent_child;
    logic       hit_aid;
    logic       go;
    logic       chan_ok;
    logic       tk_block;
    logic       p1_known;

    assign cla              = st_ff.cmd[7:0];
    assign ins              = st_ff.cmd[15:8];
    assign p1               = st_ff.cmd[23:16];
    assign p2               = st_ff.cmd[31:24];
    assign chan             = cla[1:0];
    assign data_present     = st_ff.cond[0];
    assign le_present       = st_ff.cond[1];
    assign tk_declared      = st_ff.cond[2];
    assign inc_at_max       = st_ff.cond[3];
    assign auth_fail        = st_ff.cond[4];
    assign tk_pending       = st_ff.cond[5];
    assign tk_busy          = st_ff.cond[6];
    assign tk_len           = st_ff.cond[15:8];
    assign hit_child        = st_ff.search[0];
    assign hit_parent       = st_ff.search[1];
    assign hit_parent_child = st_ff.search[2];
    // Prefix matching of a truncated name is done by the searcher.
    assign hit_aid          = st_ff.search[3];

    assign go       = psel && penable && pwrite &&
                      paddr == card_sel_pkg::ADDR_GO;
    assign chan_ok  = (chan == 2'h0) || st_ff.chan_open[chan];
    assign tk_block = tk_busy && tk_declared;
    assign p1_known = p1 == card_sel_pkg::P1_BY_FID   ||
                      p1 == card_sel_pkg::P1_CHILD    ||
                      p1 == card_sel_pkg::P1_PARENT   ||
                      p1 == card_sel_pkg::P1_BY_AID   ||
                      p1 == card_sel_pkg::P1_PATH_ROOT ||
                      p1 == card_sel_pkg::P1_PATH_CUR;

    // Returns the tag at a position of the response: the template tag
    // first, then the present objects in their fixed order.
    function automatic logic [7:0] tag_at(input logic [3:0] idx,
                                          input logic [7:0] mask,
                                          input logic [1:0] sec);
        logic [7:0] t;
        logic [3:0] n;
        t = 8'h00;
        n = 4'h1;
        if (idx == 4'h0) begin
            t = card_sel_pkg::TAG_TEMPLATE;
        end
        for (int k = 0; k < 8; k++) begin
            if (mask[k]) begin
                if (n == idx) begin
                    t = (k == card_sel_pkg::OBJ_SEC) ?
                        card_sel_pkg::SEC_TAGS[sec] :
                        card_sel_pkg::OBJ_TAGS[k];
                end
                n = n + 4'h1;
            end
        end
        return t;
    endfunction : tag_at

    always_comb begin
        logic       found;
        logic [1:0] free_chan;
        card_sel_pkg::src_type  src;
        card_sel_pkg::kind_type kind;
        nxt_st    = st_ff;
        found     = 1'b0;
        free_chan = 2'h0;
        src       = card_sel_pkg::SRC_CHILD;
        kind      = card_sel_pkg::kind_type'(st_ff.search[5:4]);

        // Read data is captured in the setup phase so that it leaves a
        // flip-flop; this is why every access is answered with no wait.
        if (psel && !penable) begin
            nxt_st.rerr = 1'b0;
            unique case (paddr)
                card_sel_pkg::ADDR_CMD:      nxt_st.rdata = st_ff.cmd;
                card_sel_pkg::ADDR_COND:     nxt_st.rdata = {16'h0000, st_ff.cond};
                card_sel_pkg::ADDR_SEARCH:   nxt_st.rdata = {21'h0, st_ff.search};
                card_sel_pkg::ADDR_GO:       nxt_st.rdata = 32'h00000000;
                card_sel_pkg::ADDR_RECPTR:   nxt_st.rdata = {31'h0, st_ff.rec_valid};
                card_sel_pkg::ADDR_STATUS:   nxt_st.rdata = {10'h0, st_ff.chan_open,
                                                st_ff.last_chan, st_ff.done, st_ff.sw};
                card_sel_pkg::ADDR_SELSTATE: nxt_st.rdata = {12'h000, st_ff.sec,
                                                st_ff.mask, st_ff.templ_req, st_ff.rec_valid,
                                                st_ff.occurrence, st_ff.session,
                                                st_ff.src, st_ff.kind};
                card_sel_pkg::ADDR_TAGIDX:   nxt_st.rdata = {28'h0000000, st_ff.tag_idx};
                card_sel_pkg::ADDR_TAG:      nxt_st.rdata = {24'h000000,
                                                tag_at(st_ff.tag_idx, st_ff.mask, st_ff.sec)};
                default: begin
                    nxt_st.rdata = 32'h00000000;
                    nxt_st.rerr  = 1'b1;
                end
            endcase
        end

        if (psel && penable && pwrite) begin
            unique case (paddr)
                card_sel_pkg::ADDR_CMD:    nxt_st.cmd    = pwdata;
                card_sel_pkg::ADDR_COND:   nxt_st.cond   = pwdata[15:0];
                card_sel_pkg::ADDR_SEARCH: nxt_st.search = pwdata[10:0];
                card_sel_pkg::ADDR_RECPTR: nxt_st.rec_valid = pwdata[0];
                card_sel_pkg::ADDR_TAGIDX: nxt_st.tag_idx = pwdata[3:0];
                default: ;
            endcase
        end

        if (go) begin
            nxt_st.done = 1'b1;
            if (!chan_ok) begin
                nxt_st.sw = card_sel_pkg::SW_NO_CHAN;
            end else if (tk_block) begin
                nxt_st.sw = card_sel_pkg::SW_TK_BUSY;
            end else if (ins == card_sel_pkg::INS_SELECT) begin
                if (!p1_known) begin
                    nxt_st.sw = card_sel_pkg::SW_BAD_P1P2;
                end else if (p1 == card_sel_pkg::P1_BY_FID && !data_present) begin
                    if (p2 == card_sel_pkg::P2_NO_DATA) begin
                        found = 1'b1;
                        src   = card_sel_pkg::SRC_ROOT;
                        kind  = card_sel_pkg::KIND_ROOT;
                    end
                end else if (p1 == card_sel_pkg::P1_BY_FID) begin
                    found = hit_child || hit_parent || hit_parent_child;
                    src   = hit_child  ? card_sel_pkg::SRC_CHILD :
                            hit_parent ? card_sel_pkg::SRC_PARENT :
                                         card_sel_pkg::SRC_PARENT_CHILD;
                end else if (p1 == card_sel_pkg::P1_BY_AID) begin
                    found = hit_aid;
                end else if (p1 == card_sel_pkg::P1_PARENT) begin
                    found = hit_parent;
                    src   = card_sel_pkg::SRC_PARENT;
                end else begin
                    found = hit_child;
                end
                if (p1_known && !found) begin
                    nxt_st.sw = (p1 == card_sel_pkg::P1_BY_FID && !data_present) ?
                                card_sel_pkg::SW_BAD_P1P2 : card_sel_pkg::SW_NOT_FOUND;
                end
                if (found) begin
                    nxt_st.kind      = kind;
                    nxt_st.src       = src;
                    nxt_st.rec_valid = 1'b0;
                    if (p1 == card_sel_pkg::P1_BY_AID) begin
                        nxt_st.session    = p2[6:5];
                        nxt_st.occurrence = p2[1:0];
                    end
                    // The template goes out only in a case with an
                    // expected length.
                    nxt_st.templ_req = !p2[7] && p2[4:2] == card_sel_pkg::P2_RET_TEMPL
                                       && le_present;
                    nxt_st.sec  = st_ff.search[7:6];
                    nxt_st.mask = 8'h00;
                    if (nxt_st.templ_req && kind != card_sel_pkg::KIND_ELEM) begin
                        nxt_st.mask = 8'hff;
                        nxt_st.mask[card_sel_pkg::OBJ_FID] =
                            kind != card_sel_pkg::KIND_APP || st_ff.search[10];
                        nxt_st.mask[card_sel_pkg::OBJ_NAME] =
                            kind == card_sel_pkg::KIND_APP;
                        nxt_st.mask[card_sel_pkg::OBJ_PROP] =
                            kind == card_sel_pkg::KIND_ROOT || st_ff.search[9];
                        nxt_st.mask[card_sel_pkg::OBJ_TOTAL] = st_ff.search[8];
                    end
                    nxt_st.sw = (tk_pending && tk_declared) ?
                                {card_sel_pkg::SW1_PENDING, tk_len} :
                                card_sel_pkg::SW_OK;
                end
            end else if (ins == card_sel_pkg::INS_INCREMENT) begin
                nxt_st.sw = inc_at_max ? card_sel_pkg::SW_INC_MAX :
                            auth_fail  ? card_sel_pkg::SW_AUTH_ERR :
                                         card_sel_pkg::SW_OK;
            end else if (ins == card_sel_pkg::INS_CHANNEL && p1 == card_sel_pkg::CHAN_OPEN) begin
                for (int c = 3; c >= 1; c--) begin
                    if (!st_ff.chan_open[c]) begin
                        free_chan = 2'(c);
                    end
                end
                if (free_chan == 2'h0) begin
                    nxt_st.sw = card_sel_pkg::SW_NO_FUNC;
                end else begin
                    nxt_st.chan_open[free_chan] = 1'b1;
                    nxt_st.last_chan = free_chan;
                    nxt_st.sw = card_sel_pkg::SW_OK;
                end
            end else if (ins == card_sel_pkg::INS_CHANNEL && p1 == card_sel_pkg::CHAN_CLOSE) begin
                if (p2[1:0] == 2'h0 || !st_ff.chan_open[p2[1:0]]) begin
                    nxt_st.sw = card_sel_pkg::SW_BAD_P1P2;
                end else begin
                    nxt_st.chan_open[p2[1:0]] = 1'b0;
                    nxt_st.sw = card_sel_pkg::SW_OK;
                end
            end else begin
                nxt_st.sw = card_sel_pkg::SW_BAD_INS;
            end
        end
    end

    // Selection state comes up with the root as the current directory.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff      <= '0;
            st_ff.sw   <= card_sel_pkg::SW_OK;
            st_ff.src  <= card_sel_pkg::SRC_ROOT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pready  = 1'b1;
    assign prdata  = st_ff.rdata;
    assign pslverr = psel && penable && st_ff.rerr;

    logic run_ok;
    assign run_ok = go && chan_ok && !tk_block;

    property p_inc_max;
        @(posedge pclk) disable iff (!presetn)
        run_ok && ins == card_sel_pkg::INS_INCREMENT && inc_at_max
        |=> st_ff.sw == 16'h9850 && st_ff.done;
    endproperty
    a_inc_max: assert property (p_inc_max) else $error("bad increment status");

    property p_auth;
        @(posedge pclk) disable iff (!presetn)
        run_ok && ins == card_sel_pkg::INS_INCREMENT && !inc_at_max && auth_fail
        |=> st_ff.sw == 16'h9862;
    endproperty
    a_auth: assert property (p_auth) else $error("bad auth status");

    property p_toolkit;
        @(posedge pclk) disable iff (!presetn)
        go && !tk_declared |=> st_ff.sw[15:8] != 8'h91 && st_ff.sw != 16'h9300;
    endproperty
    a_toolkit: assert property (p_toolkit) else $error("toolkit status leaked");

    property p_chan_closed;
        @(posedge pclk) disable iff (!presetn)
        go && cla[1:0] != 2'h0 && !st_ff.chan_open[cla[1:0]] |=> st_ff.sw == 16'h6881;
    endproperty
    a_chan_closed: assert property (p_chan_closed) else $error("closed channel ran");

    property p_basic_open;
        @(posedge pclk) disable iff (!presetn)
        go && cla[1:0] == 2'h0 |=> st_ff.sw != 16'h6881;
    endproperty
    a_basic_open: assert property (p_basic_open) else $error("channel 0 refused");

    property p_open_assign;
        @(posedge pclk) disable iff (!presetn)
        run_ok && ins == card_sel_pkg::INS_CHANNEL && p1 == 8'h00 && !(&st_ff.chan_open)
        |=> st_ff.last_chan != 2'h0 && st_ff.chan_open[st_ff.last_chan] && st_ff.sw == 16'h9000;
    endproperty
    a_open_assign: assert property (p_open_assign) else $error("open failed");

    property p_bad_ins;
        @(posedge pclk) disable iff (!presetn)
        run_ok && ins != card_sel_pkg::INS_SELECT && ins != card_sel_pkg::INS_INCREMENT
        && ins != card_sel_pkg::INS_CHANNEL |=> st_ff.sw == 16'h6d00 && $stable(st_ff.kind);
    endproperty
    a_bad_ins: assert property (p_bad_ins) else $error("unsupported command ran");

    property p_rec_undef;
        @(posedge pclk) disable iff (!presetn)
        run_ok && ins == card_sel_pkg::INS_SELECT ##1 st_ff.sw == 16'h9000 |-> !st_ff.rec_valid;
    endproperty
    a_rec_undef: assert property (p_rec_undef) else $error("record pointer kept");

    property p_root_sel;
        @(posedge pclk) disable iff (!presetn)
        run_ok && ins == card_sel_pkg::INS_SELECT && p1 == 8'h00 && !data_present && p2 == 8'h0c
        |=> st_ff.kind == card_sel_pkg::KIND_ROOT;
    endproperty
    a_root_sel: assert property (p_root_sel) else $error("root not selected");

    property p_bad_p1;
        @(posedge pclk) disable iff (!presetn)
        run_ok && ins == card_sel_pkg::INS_SELECT && !p1_known
        |=> st_ff.sw == 16'h6a86 && $stable(st_ff.kind) && $stable(st_ff.src);
    endproperty
    a_bad_p1: assert property (p_bad_p1) else $error("bad P1 accepted");

    c_select: cover property (@(posedge pclk) disable iff (!presetn)
        run_ok && ins == card_sel_pkg::INS_SELECT ##1 st_ff.sw == 16'h9000);
    c_open: cover property (@(posedge pclk) disable iff (!presetn)
        run_ok && ins == card_sel_pkg::INS_CHANNEL ##1 st_ff.last_chan == 2'h3);
    c_pending: cover property (@(posedge pclk) disable iff (!presetn)
        go ##1 st_ff.sw[15:8] == 8'h91);
endmodule : card_sel_core

// >>> test/terminal_model.sv
// Terminal model: APB master that stages command words.
`timescale 1ns/10ps
module terminal_model (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata
);
    logic hung = 1'b0;
    // The bus idles low until the first request.
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
    end
    // The request holds until pready is seen high at a rising edge, for at most 20 edges.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        hung = (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // A released bus shows no stale address or data.
        paddr <= ~a;
        pwdata <= ~d;
    endtask : xfer
endmodule : terminal_model

// >>> test/card_file_select_status_logic_bench.sv
// Self-checking bench for the card file selection and status logic.
`timescale 1ns/10ps
module card_file_select_status_logic_bench;
    logic        pclk;
    logic        presetn;
    logic        psel, penable, pwrite, pready, pslverr, e;
    logic [7:0]  paddr, p;
    logic [31:0] pwdata, prdata, q, sw, s0, sr;
    logic [15:0] x;
    logic [1:0]  ch;
    logic [7:0]  tl[$];
    int          n_fail = 0;
    int          tests_run = 0;

    card_sel_core DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    terminal_model tm (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] v, input logic [31:0] t,
                       input string m);
        tests_run++;
        if (v !== t) begin
            n_fail++;
            $display("wrong value at %0t: %s %h not %h", $time, m, v, t);
        end
    endtask : chk

    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic rd(input logic [7:0] a);
        tm.xfer(1'b0, a, 32'h0, q, e);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        tm.xfer(1'b1, a, d, q, e);
    endtask : wr

    // Every command goes whole: word, conditions, search result, start.
    task automatic run(input logic [31:0] c, input logic [31:0] cd);
        wr(card_sel_pkg::ADDR_CMD, c);
        wr(card_sel_pkg::ADDR_COND, cd);
        wr(card_sel_pkg::ADDR_SEARCH, sr);
        wr(card_sel_pkg::ADDR_GO, 32'h1);
        rd(card_sel_pkg::ADDR_STATUS);
        sw = 32'(q[15:0]);
    endtask : run

    // Selection requests keep P2 b2b1 clear unless P1 is 04.
    function automatic logic [31:0] sel(input logic [7:0] p1,
                                        input logic [7:0] p2);
        return {p2, p1, card_sel_pkg::INS_SELECT, 8'h00};
    endfunction : sel

    // Unknown objects would be skipped, so only the known order is listed.
    function automatic void tags(input logic [1:0] k);
        tl = {card_sel_pkg::TAG_TEMPLATE};
        if (k == 2'd3) return;
        tl.push_back(8'h82);
        if (k != 2'd2 || sr[10]) tl.push_back(8'h83);
        if (k == 2'd2) tl.push_back(8'h84);
        if (k == 2'd0 || sr[9]) tl.push_back(8'ha5);
        tl.push_back(8'h8a);
        tl.push_back(card_sel_pkg::SEC_TAGS[sr[7:6]]);
        tl.push_back(8'hc6);
        if (sr[8]) tl.push_back(8'h81);
    endfunction : tags

    initial begin
        wait (tm.hung);
        n_fail++;
        complete_run();
    end

    initial begin
        presetn = 1'b0;
        sr = 32'h0;
        void'($urandom(32'hb2ae));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd(card_sel_pkg::ADDR_STATUS);
        chk(32'(q[15:0]), 32'(card_sel_pkg::SW_OK), "reset");
        rd(8'h40);
        chk({31'h0, e}, 32'h1, "unmapped");
        for (int i = 0; i < 4; i++) begin
            x = i[0] ? card_sel_pkg::SW_INC_MAX : i[1] ?
                card_sel_pkg::SW_AUTH_ERR : card_sel_pkg::SW_OK;
            run({16'h0, card_sel_pkg::INS_INCREMENT, 8'h00}, 32'(i << 3));
            chk(sw, 32'(x), "increment");
            p = 8'($urandom);
            if (p inside {8'ha4, 8'h32, 8'h70}) p = 8'h00;
            run({16'h0, p, 8'h00}, 32'h0);
            chk(sw, 32'(card_sel_pkg::SW_BAD_INS), "ins");
        end
        $display("test status words done");
        for (int i = 0; i < 8; i++) begin
            p = 8'($urandom);
            x = (i[2] & i[0]) ? card_sel_pkg::SW_TK_BUSY : (i[1] & i[0]) ?
                {card_sel_pkg::SW1_PENDING, p} : card_sel_pkg::SW_OK;
            run(sel(8'h00, 8'h0c), {16'h0, p, 1'b0, i[2], i[1], 2'h0, i[0],
                2'h0});
            chk(sw, 32'(x), "toolkit");
        end
        rd(card_sel_pkg::ADDR_SELSTATE);
        chk(32'(q[3:2]), 32'h3, "root");
        run(sel(8'h00, 8'h04), 32'h0);
        chk(sw, 32'(card_sel_pkg::SW_BAD_P1P2), "root p2");
        $display("test toolkit done");
        run({16'h0, card_sel_pkg::INS_INCREMENT, 8'h01}, 32'h0);
        chk(sw, 32'(card_sel_pkg::SW_NO_CHAN), "closed");
        for (int i = 0; i < 4; i++) begin
            run({16'h0, card_sel_pkg::INS_CHANNEL, 8'h00}, 32'h0);
            x = (i < 3) ? card_sel_pkg::SW_OK : card_sel_pkg::SW_NO_FUNC;
            chk(sw, 32'(x), "open");
            if (i < 3) ch = q[18:17];
            chk(32'(ch != 2'd0), 32'h1, "number");
            run({16'h0, card_sel_pkg::INS_INCREMENT, 6'h0, ch}, 32'h0);
            chk(sw, 32'(card_sel_pkg::SW_OK), "on channel");
        end
        chk(32'(q[21:19]), 32'h7, "all open");
        run({6'h0, ch, card_sel_pkg::CHAN_CLOSE, 16'h7000}, 32'h0);
        run({16'h0, card_sel_pkg::INS_INCREMENT, 6'h0, ch}, 32'h0);
        chk(sw, 32'(card_sel_pkg::SW_NO_CHAN), "closed again");
        run({8'h00, card_sel_pkg::CHAN_CLOSE, 16'h7000}, 32'h0);
        chk(sw, 32'(card_sel_pkg::SW_BAD_P1P2), "close 0");
        $display("test channels done");
        for (int s = 0; s < 8; s++) begin
            wr(card_sel_pkg::ADDR_RECPTR, 32'h1);
            sr = 32'(s) | 32'h10;
            run(sel(8'h00, 8'h0c), 32'h1);
            x = s ? card_sel_pkg::SW_OK : card_sel_pkg::SW_NOT_FOUND;
            chk(sw, 32'(x), "fid");
            rd(card_sel_pkg::ADDR_SELSTATE);
            x = s[0] ? 16'h0 : s[1] ? 16'h1 : 16'h2;
            if (s) chk(32'({q[8], q[3:2]}), 32'(x), "src");
        end
        s0 = q;
        p = 8'($urandom);
        if (p inside {8'h00, 8'h01, 8'h03, 8'h04, 8'h08, 8'h09}) p = 8'h05;
        run(sel(p, 8'h00), 32'h1);
        chk(sw, 32'(card_sel_pkg::SW_BAD_P1P2), "p1");
        rd(card_sel_pkg::ADDR_SELSTATE);
        chk(q, s0, "kept");
        sr = 32'h9;
        for (int i = 0; i < 8; i++) begin
            p = {2'($urandom), 6'h00};
            x = {8'h0, p[7], 3'b011, 2'($urandom), 2'h0};
            run(sel(8'h04, {1'b0, p[7], 1'b0, x[6:2]}), 32'h1);
            rd(card_sel_pkg::ADDR_SELSTATE);
            chk(32'(q[7:4]), 32'({x[3:2], p[7], 1'b0}), "aid");
        end
        sr = 32'h0;
        run(sel(8'h04, 8'h0c), 32'h1);
        chk(sw, 32'(card_sel_pkg::SW_NOT_FOUND), "prefix");
        // Child, parent and both path codes, with and without a hit.
        for (int i = 0; i < 8; i++) begin
            p = i[1] ? {7'h4, i[0]} : {6'h0, i[0], 1'b1};
            sr = i[2] ? 32'h13 : 32'h10;
            run(sel(p, 8'h00), 32'h1);
            x = i[2] ? card_sel_pkg::SW_OK : card_sel_pkg::SW_NOT_FOUND;
            chk(sw, 32'(x), "p1 code");
            rd(card_sel_pkg::ADDR_SELSTATE);
            if (i[2]) chk(32'(q[3:2]), 32'(i[1:0] == 2'd1), "p1 src");
        end
        $display("test selection done");
        for (int i = 0; i < 8; i++) begin
            sr = ($urandom & 32'h7f0) | 32'h1;
            tags(sr[5:4]);
            run(sel(8'h00, (i < 7) ? 8'h04 : 8'h0c), 32'h3);
            rd(card_sel_pkg::ADDR_SELSTATE);
            chk(32'(q[9]), 32'(i < 7), "template");
            for (int j = 0; j <= tl.size(); j++) begin
                wr(card_sel_pkg::ADDR_TAGIDX, 32'(j));
                rd(card_sel_pkg::ADDR_TAG);
                x = (j < tl.size()) ? 16'(tl[j]) : 16'h0;
                if (i < 7) chk(32'(q[7:0]), 32'(x), "tag");
            end
        end
        $display("test template done");
        complete_run();
    end
endmodule : card_file_select_status_logic_bench
